// *** hw/pecc_pkg.sv ***
package pecc_pkg;

  // ==========================================================================
  // Error sources reported to the classifier.
  // ==========================================================================
  typedef enum logic [2:0] {
    PECC_SRC_DATA_LOAD  = 3'h0,
    PECC_SRC_INSN_FETCH = 3'h1,
    PECC_SRC_TABLE_WALK = 3'h2,
    PECC_SRC_STORE      = 3'h3,
    PECC_SRC_INTERNAL   = 3'h4,
    PECC_SRC_PROFILER   = 3'h5,
    PECC_SRC_POISON     = 3'h6,
    PECC_SRC_OTHER      = 3'h7
  } pecc_src_t;

  // ==========================================================================
  // Per-error outcome encoding.
  // ==========================================================================
  typedef enum logic [2:0] {
    PECC_OUT_NONE        = 3'h0,
    PECC_OUT_CORRECTED   = 3'h1,
    PECC_OUT_DEFERRED    = 3'h3,
    PECC_OUT_CONTAINED   = 3'h2,
    PECC_OUT_UNCONTAINED = 3'h6,
    PECC_OUT_LATENT      = 3'h7
  } pecc_outcome_t;

  // ==========================================================================
  // Classifier states, Gray along idle, evaluate, report.
  // ==========================================================================
  typedef enum logic [1:0] {
    PECC_ST_IDLE   = 2'h0,
    PECC_ST_EVAL   = 2'h1,
    PECC_ST_REPORT = 2'h3
  } pecc_state_t;

  // ==========================================================================
  // Widths and reset values.
  // ==========================================================================
  localparam int unsigned PECC_REC_DEPTH   = 4;
  localparam int unsigned PECC_REC_IDX_W   = 2;
  localparam int unsigned PECC_CNT_W       = 8;
  localparam logic [7:0]  PECC_CNT_RST     = 8'h00;
  localparam logic [1:0]  PECC_IDX_RST     = 2'h0;

  // Propagation cause bits.
  localparam int unsigned PECC_PROP_MEM_WR   = 0;
  localparam int unsigned PECC_PROP_SYSREG   = 1;
  localparam int unsigned PECC_PROP_SPREG    = 2;
  localparam int unsigned PECC_PROP_PROCESSOR_STATE_WORD   = 3;
  localparam int unsigned PECC_PROP_IMPRECISE = 4;
  localparam int unsigned PECC_PROP_DISCARD  = 5;
  localparam int unsigned PECC_PROP_CAUSED   = 6;
  localparam int unsigned PECC_PROP_SUPPRESS = 7;
  localparam int unsigned PECC_PROP_W        = 8;

  // Error record entry layout.
  typedef struct packed {
    logic          valid;
    pecc_src_t     src;
    pecc_outcome_t outcome;
  } pecc_rec_t;

  localparam pecc_rec_t PECC_REC_RST = '{valid: 1'b0, src: PECC_SRC_DATA_LOAD, outcome: PECC_OUT_NONE};

endpackage : pecc_pkg

// *** hw/pecc_rec_if.sv ***
`timescale 1ns/10ps
// ============================================================================
// Error record write and read paths between classifier and record store.
// ============================================================================
interface pecc_rec_if;
  import pecc_pkg::*;
  logic                      wr;
  pecc_rec_t                 entry;
  logic [PECC_REC_IDX_W-1:0] rd_idx;
  pecc_rec_t                 rd_entry;
  logic [PECC_CNT_W-1:0]     count;

  modport producer (output wr, output entry, output rd_idx, input rd_entry, input count);
  modport store    (input wr, input entry, input rd_idx, output rd_entry, output count);
endinterface : pecc_rec_if

// *** hw/pecc_rec_store.sv ***
`timescale 1ns/10ps
// ============================================================================
// Small circular error record store with a saturating log counter.
// ============================================================================
module pecc_rec_store (
  // Clock and reset.
  input  wire logic  mclk,
  input  wire logic  sys_rst,
  // Record port.
  pecc_rec_if.store  rec
);
  import pecc_pkg::*;

  typedef struct packed {
    pecc_rec_t [PECC_REC_DEPTH-1:0] mem;
    logic [PECC_REC_IDX_W-1:0]      wptr;
    logic [PECC_CNT_W-1:0]          cnt;
  } pecc_store_t;

  pecc_store_t st_reg;
  pecc_store_t st_next;

  // Oldest records are overwritten; the counter saturates so software sees overflow.
  always_comb begin
    st_next = st_reg;
    if (rec.wr) begin
      st_next.mem[st_reg.wptr] = rec.entry;
      st_next.wptr             = st_reg.wptr + 2'h1;
      if (st_reg.cnt != {PECC_CNT_W{1'b1}}) begin
        st_next.cnt = st_reg.cnt + 8'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < PECC_REC_DEPTH; i++) begin
        st_reg.mem[i] <= PECC_REC_RST;
      end
      st_reg.wptr <= PECC_IDX_RST;
      st_reg.cnt  <= PECC_CNT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read side is registered storage addressed by index.
  assign rec.rd_entry = st_reg.mem[rec.rd_idx];
  assign rec.count    = st_reg.cnt;

endmodule : pecc_rec_store

// *** hw/pecc_prop_detect.sv ***
`timescale 1ns/10ps
// ============================================================================
// Propagation and containment evaluation for one error.
// ============================================================================
module pecc_prop_detect
  import pecc_pkg::*;
(
  // Propagation causes.
  input  wire logic [PECC_PROP_W-1:0] prop_cause,
  input  wire logic                   signalled,
  // Containment conditions.
  input  wire logic                   only_gpr_fp_vec,
  input  wire logic                   after_abort_or_barrier,
  input  wire logic                   other_spread,
  input  wire logic                   containment_known,
  // Results.
  output logic                        propagated,
  output logic                        silent,
  output logic                        uncontained
);

  // Any listed cause, including speculative accesses and suppressed operations.
  assign propagated = |prop_cause;

  // Not signalled as a detected error means silent.
  assign silent = propagated & ~signalled;

  // Unknown containment is pessimistic: treated as uncontainable.
  assign uncontained = (silent & ~(only_gpr_fp_vec & after_abort_or_barrier & ~other_spread))
                     | ~containment_known;

endmodule : pecc_prop_detect

// *** hw/pecc_classifier.sv ***
`timescale 1ns/10ps
// ============================================================================
// Processing element error consumption classifier.
// ============================================================================
// Operation
// - Errors that hardware can correct or defer are corrected or deferred, not reported as uncorrected.
// - Each corrected or deferred error is logged in a record and raises the fault handling interrupt.
// - An error is consumed when an instruction commits the corrupt value into visible state.
// - A fetch error is consumed only when the fetched instruction commits.
// - A table walk error is consumed when the walk serves a committed load, store or fetch.
// - A consumed detected error always raises an error exception or enters failure mode.
// - Corrupt writes to memory or registers, imprecise exceptions and modified-data loss are propagation.
// - Operations caused or suppressed by the error, speculative ones included, are propagation.
// - A propagated error not signalled to its consumer is silently propagated.
// - A silent error is uncontained unless confined to data registers and spread only after abort or barrier.
// - Software reaches the element's own error nodes through a system register port.
// - Errors outside the architectural model come from a separate component via recovery interrupts.
// - A profiling unit is handled as a separate error-reporting component.
// - An error of unknown containability is treated as uncontainable.
// - Reading poisoned state reports a detected error unless the error is corrected.
module pecc_classifier (
  // Clock and reset.
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  // Detected error from the memory system.
  input  wire logic                        err_valid,
  input  wire pecc_pkg::pecc_src_t         err_src,
  input  wire logic                        can_correct,
  input  wire logic                        can_defer,
  input  wire logic                        committed,
  input  wire logic                        walk_for_committed,
  input  wire logic                        state_poisoned,
  input  wire logic                        failure_mode_pref,
  // Propagation and containment.
  input  wire logic [pecc_pkg::PECC_PROP_W-1:0] prop_cause,
  input  wire logic                        signalled,
  input  wire logic                        only_gpr_fp_vec,
  input  wire logic                        after_abort_or_barrier,
  input  wire logic                        other_spread,
  input  wire logic                        containment_known,
  // Recovery interrupts from separate components.
  input  wire logic                        ext_recovery_irq,
  // System register access to the element's nodes.
  input  wire logic                        sysreg_rd,
  input  wire logic [pecc_pkg::PECC_REC_IDX_W-1:0] sysreg_idx,
  output pecc_pkg::pecc_rec_t              sysreg_rdata,
  output logic [pecc_pkg::PECC_CNT_W-1:0]  sysreg_count,
  // Results.
  output logic                             busy,
  output pecc_pkg::pecc_outcome_t          outcome,
  output logic                             outcome_valid,
  output logic                             consumed,
  output logic                             fault_irq,
  output logic                             error_exception,
  output logic                             failure_mode,
  output logic                             detected_err_report,
  output logic                             ext_error_seen
);
  import pecc_pkg::*;

  typedef struct packed {
    pecc_state_t   state;
    pecc_src_t     src;
    logic          corr;
    logic          defr;
    logic          cons;
    logic          poison;
    logic          fail_pref;
    logic          uncont;
    pecc_outcome_t outcome;
    logic          out_valid;
    logic          consumed;
    logic          fault_irq;
    logic          exc;
    logic          fail;
    logic          det_rep;
    logic          ext_seen;
    pecc_rec_t     rdata;
  } pecc_cls_t;

  pecc_cls_t c_reg;
  pecc_cls_t c_next;

  logic propagated;
  logic silent;
  logic uncontained;
  logic cons_now;

  pecc_rec_if rec_bus ();

  // ==========================================================================
  // Propagation evaluator and record store.
  // ==========================================================================
  pecc_prop_detect u_prop (
    .prop_cause             (prop_cause),
    .signalled              (signalled),
    .only_gpr_fp_vec        (only_gpr_fp_vec),
    .after_abort_or_barrier (after_abort_or_barrier),
    .other_spread           (other_spread),
    .containment_known      (containment_known),
    .propagated             (propagated),
    .silent                 (silent),
    .uncontained            (uncontained)
  );

  pecc_rec_store u_store (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .rec     (rec_bus.store)
  );

  // ==========================================================================
  // Consumption decision.
  // ==========================================================================
  // Speculative fetches and walks that never commit are not consumption.
  always_comb begin
    case (err_src)
      PECC_SRC_INSN_FETCH: cons_now = committed;
      PECC_SRC_TABLE_WALK: cons_now = walk_for_committed;
      PECC_SRC_INTERNAL,
      PECC_SRC_PROFILER:   cons_now = 1'b0;
      default:             cons_now = committed;
    endcase
  end

  // ==========================================================================
  // Classification sequence: capture, evaluate, report.
  // ==========================================================================
  always_comb begin
    c_next           = c_reg;
    c_next.out_valid = 1'b0;
    c_next.fault_irq = 1'b0;
    c_next.exc       = 1'b0;
    c_next.det_rep   = 1'b0;
    c_next.ext_seen  = ext_recovery_irq;
    c_next.rdata     = rec_bus.rd_entry;
    rec_bus.wr       = 1'b0;
    rec_bus.entry    = '{valid: 1'b1, src: c_reg.src, outcome: c_reg.outcome};
    rec_bus.rd_idx   = sysreg_idx;
    case (c_reg.state)
      PECC_ST_IDLE: begin
        // Separate components report through their own interrupts, so they are not captured here.
        if (err_valid && err_src != PECC_SRC_INTERNAL && err_src != PECC_SRC_PROFILER) begin
          c_next.state     = PECC_ST_EVAL;
          c_next.src       = err_src;
          c_next.corr      = can_correct;
          c_next.defr      = can_defer & ~can_correct;
          c_next.cons      = cons_now;
          c_next.poison    = state_poisoned | (err_src == PECC_SRC_POISON);
          c_next.fail_pref = failure_mode_pref;
          c_next.uncont    = uncontained;
        end
      end
      PECC_ST_EVAL: begin
        c_next.state = PECC_ST_REPORT;
        // Correction beats deferral, and both beat reporting uncorrected.
        if (c_reg.corr) begin
          c_next.outcome = PECC_OUT_CORRECTED;
        end else if (c_reg.defr) begin
          c_next.outcome = PECC_OUT_DEFERRED;
        end else if (c_reg.uncont) begin
          c_next.outcome = PECC_OUT_UNCONTAINED;
        end else if (c_reg.cons) begin
          c_next.outcome = PECC_OUT_CONTAINED;
        end else begin
          c_next.outcome = PECC_OUT_LATENT;
        end
        c_next.consumed = c_reg.cons & ~c_reg.corr & ~c_reg.defr;
      end
      PECC_ST_REPORT: begin
        c_next.state     = PECC_ST_IDLE;
        c_next.out_valid = 1'b1;
        // Poisoned state reads back as a detected error unless the error was corrected.
        c_next.det_rep   = c_reg.poison & ~c_reg.corr;
        if (c_reg.outcome == PECC_OUT_CORRECTED || c_reg.outcome == PECC_OUT_DEFERRED) begin
          rec_bus.wr       = 1'b1;
          c_next.fault_irq = 1'b1;
        end
        // A consumed error must not go unanswered; failure mode is sticky until reset.
        if (c_reg.consumed) begin
          if (c_reg.fail_pref) begin
            c_next.fail = 1'b1;
          end else begin
            c_next.exc = 1'b1;
          end
        end
      end
      default: begin
        c_next.state = PECC_ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      c_reg           <= '0;
      c_reg.state     <= PECC_ST_IDLE;
      c_reg.src       <= PECC_SRC_DATA_LOAD;
      c_reg.outcome   <= PECC_OUT_NONE;
      c_reg.rdata     <= PECC_REC_RST;
    end else begin
      c_reg <= c_next;
    end
  end

  // ==========================================================================
  // Outputs.
  // ==========================================================================
  assign busy                = (c_reg.state != PECC_ST_IDLE);
  assign outcome             = c_reg.outcome;
  assign outcome_valid       = c_reg.out_valid;
  assign consumed            = c_reg.consumed;
  assign fault_irq           = c_reg.fault_irq;
  assign error_exception     = c_reg.exc;
  assign failure_mode        = c_reg.fail;
  assign detected_err_report = c_reg.det_rep;
  assign ext_error_seen      = c_reg.ext_seen;
  assign sysreg_rdata        = sysreg_rd ? c_reg.rdata : PECC_REC_RST;
  assign sysreg_count        = rec_bus.count;

endmodule : pecc_classifier

// *** tb/pecc_classifier_props.sv ***
`timescale 1ns/10ps
// ========
// Timing and outcome checks at the classifier ports.
module pecc_classifier_props
  import pecc_pkg::*;
(
  // Clock and reset.
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  // Request side.
  input wire logic                  err_valid,
  input wire pecc_pkg::pecc_src_t   err_src,
  input wire logic                  can_correct,
  input wire logic                  can_defer,
  input wire logic                  containment_known,
  // Results.
  input wire logic                  busy,
  input wire pecc_pkg::pecc_outcome_t outcome,
  input wire logic                  outcome_valid,
  input wire logic                  consumed,
  input wire logic                  fault_irq,
  input wire logic                  error_exception,
  input wire logic                  failure_mode,
  input wire logic [7:0]            sysreg_count
);
  import pecc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic cap;
  logic uncorr;
  // A capture is a request seen while idle from a source that belongs to the element.
  assign cap    = err_valid && !busy && !(err_src inside {PECC_SRC_INTERNAL, PECC_SRC_PROFILER});
  assign uncorr = !can_correct && !can_defer;
  AST_ANSWER_AT_3: assert property (cap |-> ##3 outcome_valid)
    else $error("outcome_valid not three cycles after capture");
  AST_VALID_PULSE: assert property (outcome_valid |=> !outcome_valid)
    else $error("outcome_valid longer than one cycle");
  AST_CORRECT_WINS: assert property (cap && can_correct |-> ##3 outcome == PECC_OUT_CORRECTED)
    else $error("correctable error not corrected");
  AST_IRQ_ON_LOG: assert property (fault_irq == (outcome_valid && outcome inside {PECC_OUT_CORRECTED, PECC_OUT_DEFERRED}))
    else $error("fault_irq does not match corrected or deferred outcome");
  // The record is written on the same edge that raises fault_irq, so the count has already stepped.
  // The counter saturates at all ones, so the step is checked only below that.
  AST_LOG_COUNT: assert property (fault_irq && $past(sysreg_count) != 8'hff |-> sysreg_count == $past(sysreg_count) + 8'h01)
    else $error("logged error did not advance the record count");
  AST_CONSUMED_ACTS: assert property (outcome_valid && consumed |-> ##[0:1] (error_exception || failure_mode))
    else $error("consumed error without exception or failure mode");
  AST_EXC_CAUSE: assert property (error_exception |-> outcome_valid && consumed)
    else $error("error exception without a consumed error");
  AST_FAIL_STICKY: assert property (failure_mode |=> failure_mode)
    else $error("failure mode left before reset");
  AST_UNKNOWN_UNCONT: assert property (cap && uncorr && !containment_known |-> ##3 outcome == PECC_OUT_UNCONTAINED)
    else $error("unknown containability not treated as uncontained");
  AST_SEPARATE_IGNORED: assert property (err_valid && !busy && !cap |=> !busy)
    else $error("separate component error was captured");
  // Main scenarios.
  COV_CORRECT: cover property (cap && can_correct);
  COV_EXCEPTION: cover property (error_exception);
  COV_UNCONT: cover property (outcome_valid && outcome == PECC_OUT_UNCONTAINED);
  COV_FAIL: cover property ($rose(failure_mode));
endmodule : pecc_classifier_props

bind pecc_classifier pecc_classifier_props u_props (.mclk, .sys_rst, .err_valid, .err_src, .can_correct,
  .can_defer, .containment_known, .busy, .outcome, .outcome_valid, .consumed, .fault_irq, .error_exception,
  .failure_mode, .sysreg_count);

// *** tb/pecc_err_source.sv ***
`timescale 1ns/10ps
// ========
// Memory system and separate error components facing the classifier.
module pecc_err_source (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Bench commands.
  input  wire logic        go,
  input  wire logic        ext_go,
  input  wire logic [21:0] req,
  // Classifier side.
  input  wire logic        busy,
  output logic             err_valid,
  output logic [21:0]      err_fields,
  output logic             ext_recovery_irq
);
  // Request is held until an edge sees the classifier idle; released fields are
  // inverted so a stale value can never pass for a live one.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      err_valid        <= 1'b0;
      err_fields       <= 22'h0;
      ext_recovery_irq <= 1'b0;
    end else begin
      ext_recovery_irq <= ext_go;
      if (go && !err_valid) begin
        err_valid  <= 1'b1;
        err_fields <= req;
      end else if (err_valid && !busy) begin
        err_valid  <= 1'b0;
        err_fields <= ~err_fields;
      end
    end
  end
endmodule : pecc_err_source

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import pecc_pkg::*;
  // ========
  // Bench signals.
  logic          mclk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          go = 1'b0;
  logic          ext_go = 1'b0;
  logic [21:0]   req = 22'h0;
  logic          sysreg_rd = 1'b0;
  logic [1:0]    sysreg_idx = 2'h0;
  logic          err_valid, ext_recovery_irq, busy, outcome_valid, consumed, fault_irq;
  logic          error_exception, failure_mode, detected_err_report, ext_error_seen;
  logic [21:0]   f;
  logic [7:0]    sysreg_count;
  pecc_rec_t     sysreg_rdata;
  pecc_outcome_t outcome;
  int            num_errors = 0;
  int            num_checks = 0;

  // Free-running 100 MHz clock.
  initial begin
    forever #5 mclk = ~mclk;
  end

  pecc_err_source u_src (.mclk(mclk), .sys_rst(sys_rst), .go(go), .ext_go(ext_go), .req(req), .busy(busy),
    .err_valid(err_valid), .err_fields(f), .ext_recovery_irq(ext_recovery_irq));

  // Field order: src, correct, defer, commit, walk, poison, pref, causes, signal, regs, after, other, known.
  pecc_classifier DUT (.mclk(mclk), .sys_rst(sys_rst), .err_valid(err_valid), .err_src(pecc_src_t'(f[21:19])),
    .can_correct(f[18]), .can_defer(f[17]), .committed(f[16]), .walk_for_committed(f[15]),
    .state_poisoned(f[14]), .failure_mode_pref(f[13]), .prop_cause(f[12:5]), .signalled(f[4]),
    .only_gpr_fp_vec(f[3]), .after_abort_or_barrier(f[2]), .other_spread(f[1]), .containment_known(f[0]),
    .ext_recovery_irq(ext_recovery_irq), .sysreg_rd(sysreg_rd), .sysreg_idx(sysreg_idx),
    .sysreg_rdata(sysreg_rdata), .sysreg_count(sysreg_count), .busy(busy), .outcome(outcome),
    .outcome_valid(outcome_valid), .consumed(consumed), .fault_irq(fault_irq),
    .error_exception(error_exception), .failure_mode(failure_mode),
    .detected_err_report(detected_err_report), .ext_error_seen(ext_error_seen));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One error through the classifier; flags are consumed, irq, exception, report.
  task automatic run(input logic [21:0] r, input pecc_outcome_t eo, input logic [3:0] ef);
    @(posedge mclk);
    req <= r;
    go  <= 1'b1;
    @(posedge mclk);
    go  <= 1'b0;
    repeat (12) begin
      @(posedge mclk);
      #1;
      if (outcome_valid === 1'b1) break;
    end
    chk(outcome_valid, 8'h01);
    chk(outcome, eo);
    chk({consumed, fault_irq, error_exception, detected_err_report}, ef);
  endtask : run

  task automatic t_correct;
    run({PECC_SRC_DATA_LOAD, 6'h38, 8'h00, 5'h01}, PECC_OUT_CORRECTED, 4'h4);
    run({PECC_SRC_DATA_LOAD, 6'h10, 8'h00, 5'h01}, PECC_OUT_DEFERRED, 4'h4);
    @(posedge mclk);
    sysreg_rd <= 1'b1;
    @(posedge mclk);
    #1;
    chk(sysreg_rdata, {1'b1, PECC_SRC_DATA_LOAD, PECC_OUT_CORRECTED});
    chk(sysreg_count, 8'h02);
    @(posedge mclk);
    sysreg_idx <= 2'h1;
    @(posedge mclk);
    #1;
    chk(sysreg_rdata, {1'b1, PECC_SRC_DATA_LOAD, PECC_OUT_DEFERRED});
    @(posedge mclk);
    sysreg_rd <= 1'b0;
    #1;
    chk(sysreg_rdata, 8'h00);
    $display("t_correct done");
  endtask : t_correct

  task automatic t_consume;
    run({PECC_SRC_DATA_LOAD, 6'h08, 8'h00, 5'h01}, PECC_OUT_CONTAINED, 4'ha);
    run({PECC_SRC_INSN_FETCH, 6'h00, 8'h00, 5'h01}, PECC_OUT_LATENT, 4'h0);
    run({PECC_SRC_INSN_FETCH, 6'h08, 8'h00, 5'h01}, PECC_OUT_CONTAINED, 4'ha);
    run({PECC_SRC_TABLE_WALK, 6'h04, 8'h00, 5'h01}, PECC_OUT_CONTAINED, 4'ha);
    run({PECC_SRC_TABLE_WALK, 6'h00, 8'h00, 5'h01}, PECC_OUT_LATENT, 4'h0);
    run({PECC_SRC_DATA_LOAD, 6'h08, 8'h00, 5'h00}, PECC_OUT_UNCONTAINED, 4'ha);
    $display("t_consume done");
  endtask : t_consume

  task automatic t_prop;
    for (int i = 0; i < 8; i++) begin
      run({PECC_SRC_DATA_LOAD, 6'h00, 8'h01 << i, 5'h01}, PECC_OUT_UNCONTAINED, 4'h0);
    end
    run({PECC_SRC_DATA_LOAD, 6'h00, 8'h01, 5'h0d}, PECC_OUT_LATENT, 4'h0);
    run({PECC_SRC_DATA_LOAD, 6'h00, 8'h01, 5'h0f}, PECC_OUT_UNCONTAINED, 4'h0);
    run({PECC_SRC_DATA_LOAD, 6'h00, 8'h01, 5'h11}, PECC_OUT_LATENT, 4'h0);
    $display("t_prop done");
  endtask : t_prop

  task automatic t_poison;
    run({PECC_SRC_DATA_LOAD, 6'h0a, 8'h00, 5'h01}, PECC_OUT_CONTAINED, 4'hb);
    run({PECC_SRC_POISON, 6'h00, 8'h00, 5'h01}, PECC_OUT_LATENT, 4'h1);
    $display("t_poison done");
  endtask : t_poison

  // Internal and profiler errors never start a classification.
  task automatic t_separate;
    for (int s = 4; s < 6; s++) begin
      @(posedge mclk);
      req <= {3'(s), 6'h08, 8'h00, 5'h01};
      go  <= 1'b1;
      @(posedge mclk);
      go  <= 1'b0;
      repeat (5) begin
        @(posedge mclk);
        #1;
        chk({busy, outcome_valid}, 8'h00);
      end
    end
    @(posedge mclk);
    ext_go <= 1'b1;
    @(posedge mclk);
    ext_go <= 1'b0;
    @(posedge mclk);
    #1;
    chk(ext_error_seen, 8'h01);
    @(posedge mclk);
    #1;
    chk(ext_error_seen, 8'h00);
    $display("t_separate done");
  endtask : t_separate

  // Failure mode is sticky, so this runs last.
  task automatic t_failure;
    run({PECC_SRC_DATA_LOAD, 6'h09, 8'h00, 5'h01}, PECC_OUT_CONTAINED, 4'h8);
    repeat (4) @(posedge mclk);
    #1;
    chk(failure_mode, 8'h01);
    $display("t_failure done");
  endtask : t_failure

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence.
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({outcome, sysreg_count[0], failure_mode}, 8'h00);
    t_correct();
    t_consume();
    t_prop();
    t_poison();
    t_separate();
    t_failure();
    tally_and_finish();
  end

  // Watchdog, far beyond the roughly 150 cycles the tests need.
  initial begin
    #50000;
    num_errors++;
    tally_and_finish();
  end
endmodule : tb_top
